// ==== verilog/isolator_switch_control_map.vh ====
// register map, field layout, codes and timing constants of the isolator switch control
`ifndef ISOLATOR_SWITCH_CONTROL_MAP_VH
`define ISOLATOR_SWITCH_CONTROL_MAP_VH

// byte offsets on the register bus
`define REG_CONTROL 6'h00
`define REG_MAX_OPERATE 6'h04
`define REG_PULSE_LENGTH 6'h08
`define REG_INTERMEDIATE 6'h0c
`define REG_SELECT_TIMEOUT 6'h10
`define REG_STATE 6'h14
`define REG_OP_COUNT 6'h18
`define REG_EVENT 6'h1c
`define REG_EVENT_MASK 6'h20

// control register fields
`define CTL_LOCAL_EN 0
`define CTL_REMOTE_EN 1
`define CTL_FORCED_CHECK 2
`define CTL_MODEL_LO 4
`define CTL_MODEL_HI 5
`define CTL_KIND_LO 8
`define CTL_KIND_HI 10

// control models
`define MODEL_DIRECT_NORMAL 2'h0
`define MODEL_DIRECT_ENHANCED 2'h1
`define MODEL_SELECT_BEFORE_OPERATE 2'h2

// switch kinds
`define KIND_NOT_APPLICABLE 3'h0
`define KIND_LOAD_BREAK 3'h1
`define KIND_DISCONNECTOR 3'h2
`define KIND_EARTHING 3'h3
`define KIND_HS_EARTHING 3'h4

// position status codes
`define POS_INTERMEDIATE 2'h0
`define POS_OPEN 2'h1
`define POS_CLOSED 2'h2
`define POS_BAD 2'h3

// event bits
`define EV_ACCEPTED 0
`define EV_REJECTED 1
`define EV_SELECT_TIMEOUT 2
`define EV_FAILED 3
`define EV_POSITION 4
`define EV_WIDTH 5

// state register fields
`define ST_POS_LO 0
`define ST_POS_HI 1
`define ST_SELECTED 2
`define ST_BUSY 3
`define ST_OPEN_OUT 4
`define ST_CLOSE_OUT 5

// reset values of the timer settings, in ms
`define MAX_OPERATE_MS 16'h03e8
`define PULSE_LENGTH_MS 16'h0064
`define INTERMEDIATE_MS 16'h0064
`define SELECT_TIMEOUT_MS 16'h1388

// time base: clock rate in MHz and one tick of 1000 us
`define CLK_MHZ 25
`define TICK_US 1000

`endif

// ==== verilog/isolator_switch_control.v ====
// isolator switch command interpreter with avalon-mm register slave
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "isolator_switch_control_map.vh"

// Operation
// - accept remote and local commands, forward checked
// - separate local and remote enables, reject disabled
// - open needs trip permit, close needs close permit
// - block input stops all command execution
// - direct normal passes commands without status checks
// - direct enhanced checks status, supervises completion
// - select-before-operate executes only selected object; local on/off commands execute without a selection
// - selection expires after select timeout, no command
// - failure when position not reached in time
// - open and close outputs are programmable pulses
// - intermediate position reported after wait time
// - position code intermediate, open, closed, bad
// - forced check ignores command bypass attribute
// - local on/off channel is a local source
// - switch kind setting, five values, default disconnector
// - timers within five percent or 15 ms
module isolator_switch_control #(
  parameter MS_CYCLES = `CLK_MHZ * `TICK_US,
  parameter TICK_W = 15,
  parameter TW = 16,
  parameter CNT_W = 16
) (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  // avalon-mm slave
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output wire [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // remote commands from the station control system
  input wire REMOTE_SELECT,
  input wire REMOTE_OPERATE,
  input wire REMOTE_CANCEL,
  input wire REMOTE_CLOSE,
  input wire REMOTE_BYPASS,
  // local operate command channel
  input wire LOCAL_ON,
  input wire LOCAL_OFF,
  // interlocks and block
  input wire TRIP_PERMIT,
  input wire CLOSE_PERMIT,
  input wire BLOCK,
  // switch feedback and drive
  input wire POS_OPEN,
  input wire POS_CLOSED,
  output wire OPEN_PULSE,
  output wire CLOSE_PULSE,
  output wire [1:0] POSITION_STATUS,
  output wire SELECTED,
  // interrupt
  output wire IRQ
);

  localparam S_IDLE = 2'h0;
  localparam S_SELECTED = 2'h1;
  localparam S_ACTIVE = 2'h2;

  // settings
  reg local_en;
  reg remote_en;
  reg forced_check_flag;
  reg [1:0] control_model_setting;
  reg [2:0] switch_kind_setting;
  reg [TW-1:0] max_operate_time;
  reg [TW-1:0] command_pulse_length;
  reg [TW-1:0] intermediate_wait_time;
  reg [TW-1:0] select_timeout;
  reg [`EV_WIDTH-1:0] event_status;
  reg [`EV_WIDTH-1:0] event_mask;

  // bus
  reg served;
  reg [31:0] rdata;
  wire bus_req = AVS_READ | AVS_WRITE;
  wire wr_take = AVS_WRITE & served;

  // time base
  reg [TICK_W-1:0] tick_cnt;
  wire tick = (tick_cnt == MS_CYCLES[TICK_W-1:0] - 1'b1);

  // position filter
  reg [1:0] position_status_code;
  reg [TW-1:0] mid_ms;
  reg ev_position;

  // command sequencer
  reg [1:0] state;
  reg sel_close;
  reg sel_bypass;
  reg act_close;
  reg act_supervise;
  reg done;
  reg open_out;
  reg close_out;
  reg [TW-1:0] op_ms;
  reg [TW-1:0] sel_ms;
  reg [CNT_W-1:0] op_count;
  reg ev_accepted;
  reg ev_rejected;
  reg ev_sel_timeout;
  reg ev_failed;

  // one ms tick, error one tick at most
  always @(posedge CLK) begin
    if (!RSTN || tick)
      tick_cnt <= {TICK_W{1'b0}};
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  // raw position from the two auxiliary contacts
  reg [1:0] raw_pos;
  always @* begin
    case ({POS_CLOSED, POS_OPEN})
      2'b01: raw_pos = `POS_OPEN;
      2'b10: raw_pos = `POS_CLOSED;
      2'b11: raw_pos = `POS_BAD;
      default: raw_pos = `POS_INTERMEDIATE;
    endcase
  end

  // travel between end positions is normal, so it only shows after the wait
  always @(posedge CLK) begin
    if (!RSTN) begin
      position_status_code <= `POS_INTERMEDIATE;
      mid_ms <= {TW{1'b0}};
      ev_position <= 1'b0;
    end else begin
      ev_position <= 1'b0;
      if (raw_pos != `POS_INTERMEDIATE) begin
        mid_ms <= {TW{1'b0}};
        if (position_status_code != raw_pos) begin
          position_status_code <= raw_pos;
          ev_position <= 1'b1;
        end
      end else if (mid_ms >= intermediate_wait_time) begin
        if (position_status_code != `POS_INTERMEDIATE) begin
          position_status_code <= `POS_INTERMEDIATE;
          ev_position <= 1'b1;
        end
      end else if (tick) begin
        mid_ms <= mid_ms + 1'b1;
      end
    end
  end

  // candidate command this cycle; remote wins over local
  wire rem_req = REMOTE_OPERATE;
  wire loc_req = LOCAL_ON | LOCAL_OFF;
  wire req = rem_req | loc_req;
  wire cmd_close = rem_req ? REMOTE_CLOSE : LOCAL_ON;
  wire loc_conflict = ~rem_req & LOCAL_ON & LOCAL_OFF;
  wire enhanced = (control_model_setting != `MODEL_DIRECT_NORMAL);
  wire select_before_operate = (control_model_setting == `MODEL_SELECT_BEFORE_OPERATE);
  // bypass honoured only while forced check is clear
  wire cmd_bypass = rem_req & ~forced_check_flag &
    (select_before_operate ? sel_bypass : REMOTE_BYPASS);
  // local channel checked against local enable
  wire src_en = rem_req ? remote_en : local_en;
  wire permit = cmd_close ? CLOSE_PERMIT : TRIP_PERMIT;
  wire [1:0] target = cmd_close ? `POS_CLOSED : `POS_OPEN;
  // status check, refuse if already there or bad
  wire status_ok = ~enhanced |
    ((position_status_code != target) && (position_status_code != `POS_BAD));
  wire sel_ok = ~(rem_req & select_before_operate) | ((state == S_SELECTED) && (sel_close == cmd_close));
  wire ready = (state == S_IDLE) || (state == S_SELECTED);
  wire accept = req & ready & ~BLOCK & src_en & ~loc_conflict & sel_ok &
    (cmd_bypass | (permit & status_ok));
  wire sel_accept = REMOTE_SELECT & ~rem_req & select_before_operate & (state == S_IDLE) & ~BLOCK & remote_en;
  wire sel_reject = REMOTE_SELECT & ~rem_req & ~sel_accept;
  wire pulse_end = (op_ms >= command_pulse_length);
  wire reached = (position_status_code == (act_close ? `POS_CLOSED : `POS_OPEN));

  always @(posedge CLK) begin
    if (!RSTN) begin
      state <= S_IDLE;
      sel_close <= 1'b0;
      sel_bypass <= 1'b0;
      act_close <= 1'b0;
      act_supervise <= 1'b0;
      done <= 1'b0;
      open_out <= 1'b0;
      close_out <= 1'b0;
      op_ms <= {TW{1'b0}};
      sel_ms <= {TW{1'b0}};
      op_count <= {CNT_W{1'b0}};
      ev_accepted <= 1'b0;
      ev_rejected <= 1'b0;
      ev_sel_timeout <= 1'b0;
      ev_failed <= 1'b0;
    end else begin
      ev_accepted <= accept | sel_accept;
      ev_rejected <= (req & ~accept) | sel_reject;
      ev_sel_timeout <= 1'b0;
      ev_failed <= 1'b0;
      case (state)
        S_IDLE: begin
          if (sel_accept) begin
            state <= S_SELECTED;
            sel_close <= REMOTE_CLOSE;
            sel_bypass <= REMOTE_BYPASS;
            sel_ms <= {TW{1'b0}};
          end
        end
        S_SELECTED: begin
          if (BLOCK || REMOTE_CANCEL) begin
            state <= S_IDLE;
          end else if (!accept && sel_ms >= select_timeout) begin
            state <= S_IDLE;
            ev_sel_timeout <= 1'b1;
          end else if (tick) begin
            sel_ms <= sel_ms + 1'b1;
          end
        end
        S_ACTIVE: begin
          if (tick)
            op_ms <= op_ms + 1'b1;
          if (act_supervise && reached && !done) begin
            done <= 1'b1;
            op_count <= op_count + 1'b1;
          end
          // aborting a running pulse is the safe reading of a block
          if (BLOCK) begin
            open_out <= 1'b0;
            close_out <= 1'b0;
            state <= S_IDLE;
            ev_failed <= ~done;
          end else if (act_supervise && !done && !reached && op_ms >= max_operate_time) begin
            open_out <= 1'b0;
            close_out <= 1'b0;
            state <= S_IDLE;
            ev_failed <= 1'b1;
          end else if (pulse_end) begin
            open_out <= 1'b0;
            close_out <= 1'b0;
            if (!act_supervise) begin
              op_count <= op_count + 1'b1;
              state <= S_IDLE;
            end else if (done || reached) begin
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
      if (accept) begin
        state <= S_ACTIVE;
        act_close <= cmd_close;
        act_supervise <= enhanced & ~cmd_bypass;
        done <= 1'b0;
        op_ms <= {TW{1'b0}};
        open_out <= ~cmd_close;
        close_out <= cmd_close;
      end
    end
  end

  // events, set wins over a clearing write
  wire [`EV_WIDTH-1:0] ev_set = {ev_position, ev_failed, ev_sel_timeout,
    ev_rejected, ev_accepted};
  wire [`EV_WIDTH-1:0] ev_clr = (wr_take && AVS_ADDRESS == `REG_EVENT) ?
    AVS_WRITEDATA[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

  always @(posedge CLK) begin
    if (!RSTN)
      event_status <= {`EV_WIDTH{1'b0}};
    else
      event_status <= (event_status & ~ev_clr) | ev_set;
  end

  // settings writes; take effect at the edge where waitrequest is low
  always @(posedge CLK) begin
    if (!RSTN) begin
      local_en <= 1'b0;
      remote_en <= 1'b0;
      forced_check_flag <= 1'b0;
      control_model_setting <= `MODEL_DIRECT_NORMAL;
      switch_kind_setting <= `KIND_DISCONNECTOR;
      max_operate_time <= `MAX_OPERATE_MS;
      command_pulse_length <= `PULSE_LENGTH_MS;
      intermediate_wait_time <= `INTERMEDIATE_MS;
      select_timeout <= `SELECT_TIMEOUT_MS;
      event_mask <= {`EV_WIDTH{1'b0}};
    end else if (wr_take) begin
      case (AVS_ADDRESS)
        `REG_CONTROL: begin
          local_en <= AVS_WRITEDATA[`CTL_LOCAL_EN];
          remote_en <= AVS_WRITEDATA[`CTL_REMOTE_EN];
          forced_check_flag <= AVS_WRITEDATA[`CTL_FORCED_CHECK];
          // unused model code would act as direct enhanced; kept as written
          control_model_setting <= AVS_WRITEDATA[`CTL_MODEL_HI:`CTL_MODEL_LO];
          switch_kind_setting <= AVS_WRITEDATA[`CTL_KIND_HI:`CTL_KIND_LO];
        end
        `REG_MAX_OPERATE: max_operate_time <= AVS_WRITEDATA[TW-1:0];
        `REG_PULSE_LENGTH: command_pulse_length <= AVS_WRITEDATA[TW-1:0];
        `REG_INTERMEDIATE: intermediate_wait_time <= AVS_WRITEDATA[TW-1:0];
        `REG_SELECT_TIMEOUT: select_timeout <= AVS_WRITEDATA[TW-1:0];
        `REG_EVENT_MASK: event_mask <= AVS_WRITEDATA[`EV_WIDTH-1:0];
        default: event_mask <= event_mask;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (AVS_ADDRESS)
      `REG_CONTROL: begin
        next_rdata[`CTL_LOCAL_EN] = local_en;
        next_rdata[`CTL_REMOTE_EN] = remote_en;
        next_rdata[`CTL_FORCED_CHECK] = forced_check_flag;
        next_rdata[`CTL_MODEL_HI:`CTL_MODEL_LO] = control_model_setting;
        next_rdata[`CTL_KIND_HI:`CTL_KIND_LO] = switch_kind_setting;
      end
      `REG_MAX_OPERATE: next_rdata[TW-1:0] = max_operate_time;
      `REG_PULSE_LENGTH: next_rdata[TW-1:0] = command_pulse_length;
      `REG_INTERMEDIATE: next_rdata[TW-1:0] = intermediate_wait_time;
      `REG_SELECT_TIMEOUT: next_rdata[TW-1:0] = select_timeout;
      `REG_STATE: begin
        next_rdata[`ST_POS_HI:`ST_POS_LO] = position_status_code;
        next_rdata[`ST_SELECTED] = (state == S_SELECTED);
        next_rdata[`ST_BUSY] = (state == S_ACTIVE);
        next_rdata[`ST_OPEN_OUT] = open_out;
        next_rdata[`ST_CLOSE_OUT] = close_out;
      end
      `REG_OP_COUNT: next_rdata[CNT_W-1:0] = op_count;
      `REG_EVENT: next_rdata[`EV_WIDTH-1:0] = event_status;
      `REG_EVENT_MASK: next_rdata[`EV_WIDTH-1:0] = event_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // fixed one wait state: served marks the completing cycle
  always @(posedge CLK) begin
    if (!RSTN) begin
      served <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      served <= bus_req & ~served;
      if (AVS_READ && !served)
        rdata <= next_rdata;
    end
  end

  assign AVS_WAITREQUEST = bus_req & ~served;
  assign AVS_READDATA = rdata;
  assign OPEN_PULSE = open_out;
  assign CLOSE_PULSE = close_out;
  assign POSITION_STATUS = position_status_code;
  assign SELECTED = (state == S_SELECTED);
  assign IRQ = |(event_status & event_mask);

endmodule // isolator_switch_control
`default_nettype wire

// ==== verification/isolator_switch_control_checker.sv ====
// port assertions for the isolator switch control
`timescale 1ns/100ps
`default_nettype none
module isolator_switch_control_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // commands and interlocks
  input wire logic REMOTE_SELECT,
  input wire logic REMOTE_BYPASS,
  input wire logic TRIP_PERMIT,
  input wire logic CLOSE_PERMIT,
  input wire logic BLOCK,
  // switch side
  input wire logic POS_OPEN,
  input wire logic POS_CLOSED,
  input wire logic OPEN_PULSE,
  input wire logic CLOSE_PULSE,
  input wire logic [1:0] POSITION_STATUS,
  input wire logic SELECTED
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  AST_BLOCK: assert property ($rose(OPEN_PULSE || CLOSE_PULSE) |-> !$past(BLOCK))
    else $error("pulse started while blocked");
  AST_TRIP: assert property ($rose(OPEN_PULSE) |-> $past(TRIP_PERMIT || REMOTE_BYPASS))
    else $error("open pulse without trip permit");
  AST_CLOSE: assert property ($rose(CLOSE_PULSE) |-> $past(CLOSE_PERMIT || REMOTE_BYPASS))
    else $error("close pulse without close permit");
  AST_EXCLUSIVE: assert property (!(OPEN_PULSE && CLOSE_PULSE))
    else $error("open and close pulses together");
  AST_CODE: assert property (
    ($past(RSTN) && $past(RSTN, 2) && $past(POS_OPEN) != $past(POS_CLOSED))
    |-> POSITION_STATUS == {$past(POS_CLOSED), $past(POS_OPEN)})
    else $error("position code does not follow contacts");
  AST_BAD: assert property (
    ($past(RSTN) && $past(RSTN, 2) && $past(POS_OPEN && POS_CLOSED))
    |-> POSITION_STATUS == 2'h3)
    else $error("bad position not reported");
  AST_FILTER: assert property (
    (POSITION_STATUS != 2'h0 && !POS_OPEN && !POS_CLOSED
    && $past(POS_OPEN || POS_CLOSED)) |=> (POSITION_STATUS != 2'h0) [*8])
    else $error("intermediate shown before wait time");
  AST_SELECT: assert property ($rose(SELECTED) |-> $past(REMOTE_SELECT))
    else $error("selected without select request");
endmodule // isolator_switch_control_checker
`default_nettype wire

// ==== verification/switch_mechanism_model.sv ====
// disconnector mechanism model driven by the open and close pulses
`timescale 1ns/100ps
`default_nettype none
module switch_mechanism_model #(
  parameter int TRAVEL = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // drive and test controls
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic move_en,
  input wire logic make_bad,
  // auxiliary contacts
  output logic pos_open,
  output logic pos_closed
);
  int cnt;
  logic at_open, at_closed, to_closed;
  // both contacts made means a broken indication
  assign pos_open = at_open | make_bad;
  assign pos_closed = at_closed | make_bad;
  always @(posedge clk) begin
    if (!rstn) begin
      cnt <= 0;
      at_open <= 1'b1;
      at_closed <= 1'b0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      at_open <= cnt == 1 && !to_closed;
      at_closed <= cnt == 1 && to_closed;
    end else if (move_en && (close_cmd && !at_closed || open_cmd && !at_open)) begin
      // travel leaves both contacts open; a stuck mechanism never moves
      to_closed <= close_cmd;
      cnt <= TRAVEL;
      at_open <= 1'b0;
      at_closed <= 1'b0;
    end
  end
endmodule // switch_mechanism_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking testbench for the isolator switch control
`timescale 1ns/100ps
`default_nettype none
`include "isolator_switch_control_map.vh"
module testbench;
  localparam int MS = 10;
  localparam int PL = 50 * MS;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd = 1'b0, wr = 1'b0, r_close = 1'b0, trip = 1'b1, cls = 1'b1, blk = 1'b0;
  logic sel = 1'b0, op = 1'b0, l_on = 1'b0, l_off = 1'b0, move = 1'b0, bad = 1'b0;
  logic byp = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, q;
  wire [31:0] rdata;
  wire wreq, open_p, close_p, selected, irq, p_open, p_closed;
  wire [1:0] status;
  int error_cnt = 0, cmp_count = 0, len;
  logic wclose;
  always #20 clk = ~clk;
  isolator_switch_control #(.MS_CYCLES(MS)) DUT (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .REMOTE_SELECT(sel), .REMOTE_OPERATE(op), .REMOTE_CANCEL(1'b0),
    .REMOTE_CLOSE(r_close), .REMOTE_BYPASS(byp), .LOCAL_ON(l_on), .LOCAL_OFF(l_off),
    .TRIP_PERMIT(trip), .CLOSE_PERMIT(cls), .BLOCK(blk), .POS_OPEN(p_open),
    .POS_CLOSED(p_closed), .OPEN_PULSE(open_p), .CLOSE_PULSE(close_p),
    .POSITION_STATUS(status), .SELECTED(selected), .IRQ(irq));
  switch_mechanism_model MECH (.clk(clk), .rstn(rstn), .open_cmd(open_p), .close_cmd(close_p),
    .move_en(move), .make_bad(bad), .pos_open(p_open), .pos_closed(p_closed));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask
  // one request held until waitrequest is sampled low
  // only the watchdog ends a wait that never completes
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask
  // position change bit is left out, the mechanism sets it freely
  task automatic ev(input logic [3:0] e);
    bus(1'b0, `REG_EVENT, 32'h0);
    check(q & 32'hf, {28'h0, e});
    bus(1'b1, `REG_EVENT, 32'h1f);
  endtask
  // one-cycle command, then length of any pulse that follows
  task automatic cmd(input logic [3:0] v);
    int n;
    @(posedge clk);
    {sel, op, l_on, l_off} <= v;
    @(posedge clk);
    {sel, op, l_on, l_off} <= 4'h0;
    len = 0;
    for (n = 0; n < 4 && (open_p | close_p) !== 1'b1; n++) @(posedge clk);
    wclose = close_p;
    while ((open_p | close_p) === 1'b1 && len < 40000) begin
      @(posedge clk);
      len++;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset();
    rchk(`REG_CONTROL, 32'h200);
    rchk(`REG_PULSE_LENGTH, 32'h64);
    rchk(`REG_MAX_OPERATE, 32'h3e8);
    rchk(`REG_SELECT_TIMEOUT, 32'h1388);
    rchk(`REG_INTERMEDIATE, 32'h64);
    rchk(6'h3c, 32'h0);
    ev(4'h0);
  endtask
  task automatic t_disabled();
    cmd(4'h2);
    check(len, 0);
    ev(4'h2);
    bus(1'b1, `REG_CONTROL, 32'h203);
    bus(1'b1, `REG_PULSE_LENGTH, 32'h32);
    bus(1'b1, `REG_MAX_OPERATE, 32'h14);
    bus(1'b1, `REG_INTERMEDIATE, 32'h14);
    bus(1'b1, `REG_SELECT_TIMEOUT, 32'h3e8);
  endtask
  task automatic t_interlock();
    trip <= 1'b0;
    cmd(4'h1);
    check(len, 0);
    ev(4'h2);
    trip <= 1'b1;
    cls <= 1'b0;
    cmd(4'h2);
    check(len, 0);
    cls <= 1'b1;
    blk <= 1'b1;
    cmd(4'h2);
    check(len, 0);
    ev(4'h2);
    blk <= 1'b0;
  endtask
  task automatic t_normal();
    cmd(4'h2);
    check(wclose, 1'b1);
    // the first partial ms counts as a whole one, so a pulse may run up to one ms short
    rng(len, PL - MS, PL + 3);
    ev(4'h1);
    rchk(`REG_OP_COUNT, 32'h1);
  endtask
  task automatic t_enhanced();
    bus(1'b1, `REG_CONTROL, 32'h213);
    move <= 1'b1;
    cmd(4'h2);
    rng(len, PL - MS, PL + 3);
    ev(4'h1);
    check(status, 2'h2);
    rchk(`REG_OP_COUNT, 32'h2);
    cmd(4'h2);
    check(len, 0);
    ev(4'h2);
    move <= 1'b0;
    cmd(4'h1);
    rng(len, 19 * MS, 20 * MS + 3);
    ev(4'h9);
    rchk(`REG_OP_COUNT, 32'h2);
  endtask
  task automatic t_irq();
    bus(1'b1, `REG_EVENT_MASK, 32'h2);
    cmd(4'h2);
    check(irq, 1'b1);
    bus(1'b1, `REG_EVENT, 32'h1f);
    @(posedge clk);
    check(irq, 1'b0);
    bad <= 1'b1;
    repeat (3) @(posedge clk);
    check(status, 2'h3);
    bad <= 1'b0;
  endtask
  task automatic t_sbo();
    bus(1'b1, `REG_CONTROL, 32'h223);
    move <= 1'b1;
    r_close <= 1'b0;
    cmd(4'h4);
    check(len, 0);
    ev(4'h2);
    cmd(4'h8);
    check(selected, 1'b1);
    rchk(`REG_STATE, 32'h6);
    cmd(4'h4);
    rng(len, PL - MS, PL + 3);
    check(wclose, 1'b0);
    check(status, 2'h1);
    ev(4'h1);
    r_close <= 1'b1;
    cmd(4'h8);
    len = 0;
    while (selected === 1'b1 && len < 20000) begin
      @(posedge clk);
      len++;
    end
    rng(len, 1000 * MS - 2 * MS, 1000 * MS + 3);
    // the select itself also sets the accepted bit
    ev(4'h5);
  endtask
  // already open: only a bypass can pass the status check
  task automatic t_bypass();
    bus(1'b1, `REG_CONTROL, 32'h217);
    r_close <= 1'b0;
    byp <= 1'b1;
    cmd(4'h4);
    check(len, 0);
    ev(4'h2);
    bus(1'b1, `REG_CONTROL, 32'h213);
    cmd(4'h4);
    rng(len, PL - MS, PL + 3);
    ev(4'h1);
    byp <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_disabled();
    t_interlock();
    t_normal();
    t_enhanced();
    t_irq();
    t_sbo();
    t_bypass();
    print_verdict();
  end
  // the whole run needs about 12500 cycles
  initial begin
    #(40 * 60000);
    error_cnt++;
    print_verdict();
  end
endmodule // testbench
bind isolator_switch_control isolator_switch_control_checker CHK (.CLK(CLK), .RSTN(RSTN),
  .REMOTE_SELECT(REMOTE_SELECT), .REMOTE_BYPASS(REMOTE_BYPASS), .TRIP_PERMIT(TRIP_PERMIT),
  .CLOSE_PERMIT(CLOSE_PERMIT), .BLOCK(BLOCK), .POS_OPEN(POS_OPEN), .POS_CLOSED(POS_CLOSED),
  .OPEN_PULSE(OPEN_PULSE), .CLOSE_PULSE(CLOSE_PULSE), .POSITION_STATUS(POSITION_STATUS),
  .SELECTED(SELECTED));
`default_nettype wire
